// *** rtl/pps_debounce.sv ***
`timescale 1ns/1ps
// holds a rising connect level until stable for the full count; drops at once
module pps_debounce import pps_pkg::*; #(
    parameter int COUNT = DEBOUNCE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw,
    output logic stable
);
    logic [DBC_W-1:0] cnt_q;

    initial begin
        if (COUNT < 1 || COUNT >= (1 << DBC_W)) $error("pps_debounce: bad COUNT");
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !raw) begin
            cnt_q <= '0;
        end else if (!stable && cnt_q != DBC_W'(COUNT - 1)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !raw) begin
            stable <= 1'b0;
        end else if (cnt_q == DBC_W'(COUNT - 1)) begin
            stable <= 1'b1;
        end
    end
endmodule // pps_debounce

// *** rtl/pps_pkg.sv ***
package pps_pkg;
    localparam int NUM_PORTS = 3;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // register map, index = bus address
    localparam logic [3:0] REG_ID_CPS = 4'h0;
    localparam logic [3:0] REG_PORT1 = 4'h3;
    localparam logic [3:0] REG_IRQ_CPS = 4'h6;
    // field positions, bit 0 is the left-most column (msb)
    localparam int ID_CPS_BIT = 7;
    localparam int PORT_B_HI = 2;
    localparam int PORT_B_LO = 3;
    localparam int PORT_CH_BIT = 4;
    localparam int PORT_CON_BIT = 5;
    localparam int IRQ_CABLE_POWER_DROP_IRQ_BIT = 1;
    localparam int IRQ_CPS_BIT = 2;
    localparam int IRQ_MGR_BIT = 7;
    // line-state codes
    localparam logic [1:0] LINE_INVALID = 2'h0;
    localparam logic [1:0] LINE_ONE = 2'h1;
    localparam logic [1:0] LINE_ZERO = 2'h2;
    localparam logic [1:0] LINE_HIZ = 2'h3;
    // debounce time
    localparam int CLK_KHZ = 100_000;
    localparam int DEBOUNCE_MS = 335;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
    localparam int DBC_W = 26;
    localparam logic [7:0] PHY_ADDR_ROOT = 8'h00;
endpackage

// *** rtl/pps_status_regs.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - b-pair line state per port: 11 hi-z, 01 one, 10 zero
// - line state reads 00 after reset and while transmitting or receiving
// - manager flag mirrors the manager-capable pin and feeds self-id
// - child flag 1 for child, 0 parent; invalid until tree-id done
// - connected flag 1 when connected; refreshed during bus reset
// - hardware reset marks ports disconnected; the two statements conflict
// - new connection starts bus reset only after 335 ms stable
// - disconnect starts bus reset at once
// - after hardware reset, all ports disconnected children, cable drivers off
// - after that self-id report root with address 00h
// - cable power ok follows the sense input, 0 when low
// - cable power ok readable at two register addresses
// - cable power interrupt flag sets whenever sense falls low
// - interrupt flag clears on reset or when 0 is written
// - clearing while sense still low sets the flag again
module pps_status_regs import pps_pkg::*; #(
    parameter int DEBOUNCE = DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // register port
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    output logic [DATA_W-1:0] REG_RDATA,
    // cable side
    input wire logic [2*NUM_PORTS-1:0] CABLE_PAIR_B,
    input wire logic [NUM_PORTS-1:0] CABLE_PRESENT,
    input wire logic LINE_BUSY,
    input wire logic [NUM_PORTS-1:0] TREE_CHILD,
    input wire logic TREE_DONE,
    input wire logic SELF_ID_DONE,
    // straps
    input wire logic MGR_CAPABLE_PIN,
    input wire logic CABLE_POWER_SENSE,
    // status out
    output logic BUS_RESET_REQ,
    output logic CABLE_DRIVE_EN,
    output logic SELF_ID_MGR,
    output logic IS_ROOT,
    output logic [7:0] PHY_ADDR
);
    logic [2*NUM_PORTS-1:0] b_line_q;
    logic [NUM_PORTS-1:0] child_q;
    logic [NUM_PORTS-1:0] con_q;
    logic [NUM_PORTS-1:0] stable;
    logic [NUM_PORTS-1:0] stable_q;
    logic mgr_q;
    logic cps_q;
    logic cps_prev_q;
    logic irq_q;
    logic init_q;
    logic clear_wr;
    logic [DATA_W-1:0] rd_d;

    initial begin
        if (NUM_PORTS != 3) $error("pps_status_regs: three ports expected");
    end

    // per-port debounce and line state
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            pps_debounce #(.COUNT(DEBOUNCE)) u_dbc (
                .clk(MCLK),
                .rst_n(RESET_N),
                .raw(CABLE_PRESENT[gi]),
                .stable(stable[gi])
            );
            always_ff @(posedge MCLK) begin
                if (!RESET_N || LINE_BUSY) begin
                    b_line_q[2*gi+1:2*gi] <= LINE_INVALID;
                end else begin
                    b_line_q[2*gi+1:2*gi] <= CABLE_PAIR_B[2*gi+1:2*gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK) begin
        stable_q <= RESET_N ? stable : '0;
    end

    // connection flags refreshed while bus reset runs
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            con_q <= '0;
        end else if (BUS_RESET_REQ) begin
            con_q <= stable;
        end
    end

    // child flags follow tree-id result once done
    always_ff @(posedge MCLK) begin
        if (!RESET_N || init_q) begin
            child_q <= '1;
        end else if (TREE_DONE) begin
            child_q <= TREE_CHILD;
        end
    end

    // bus reset on new stable connect or any disconnect
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            BUS_RESET_REQ <= 1'b0;
        end else begin
            BUS_RESET_REQ <= |(stable & ~stable_q) || |(stable_q & ~stable);
        end
    end

    // isolated start-up phase after hardware reset
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            init_q <= 1'b1;
        end else if (BUS_RESET_REQ) begin
            init_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            CABLE_DRIVE_EN <= 1'b0;
            IS_ROOT <= 1'b0;
            PHY_ADDR <= PHY_ADDR_ROOT;
        end else begin
            CABLE_DRIVE_EN <= !init_q;
            if (init_q && SELF_ID_DONE) begin
                IS_ROOT <= 1'b1;
                PHY_ADDR <= PHY_ADDR_ROOT;
            end else if (BUS_RESET_REQ) begin
                IS_ROOT <= 1'b0;
            end
        end
    end

    // straps sampled on the system clock
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            mgr_q <= 1'b0;
            cps_q <= 1'b0;
            cps_prev_q <= 1'b0;
            SELF_ID_MGR <= 1'b0;
        end else begin
            mgr_q <= MGR_CAPABLE_PIN;
            SELF_ID_MGR <= mgr_q;
            cps_q <= CABLE_POWER_SENSE;
            cps_prev_q <= cps_q;
        end
    end

    assign clear_wr = REG_WR && REG_ADDR == REG_IRQ_CPS && !REG_WDATA[7-IRQ_CABLE_POWER_DROP_IRQ_BIT];

    // sticky power interrupt, set wins over clear
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            irq_q <= 1'b0;
        end else if ((cps_prev_q && !cps_q) || (clear_wr && !cps_q)) begin
            irq_q <= 1'b1;
        end else if (clear_wr) begin
            irq_q <= 1'b0;
        end
    end

    // read mux, bit 0 of the map is the data msb
    always_comb begin
        rd_d = '0;
        if (REG_ADDR == REG_ID_CPS) begin
            rd_d[7-ID_CPS_BIT] = cps_q;
        end else if (REG_ADDR >= REG_PORT1 && REG_ADDR < REG_PORT1 + 4'(NUM_PORTS)) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (REG_ADDR == REG_PORT1 + 4'(p)) begin
                    rd_d[7-PORT_B_HI] = b_line_q[2*p+1];
                    rd_d[7-PORT_B_LO] = b_line_q[2*p];
                    rd_d[7-PORT_CH_BIT] = child_q[p];
                    rd_d[7-PORT_CON_BIT] = con_q[p];
                end
            end
        end else if (REG_ADDR == REG_IRQ_CPS) begin
            rd_d[7-IRQ_CABLE_POWER_DROP_IRQ_BIT] = irq_q;
            rd_d[7-IRQ_CPS_BIT] = cps_q;
            rd_d[7-IRQ_MGR_BIT] = mgr_q;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            REG_RDATA <= '0;
        end else begin
            REG_RDATA <= rd_d;
        end
    end

    AST_CPS_FALL_SETS: assert property (@(posedge MCLK) disable iff (!RESET_N)
        cps_prev_q && !cps_q |=> irq_q)
        else $error("power interrupt not set on fall");
    AST_CLEAR_RESETS: assert property (@(posedge MCLK) disable iff (!RESET_N)
        clear_wr && cps_q && !(cps_prev_q && !cps_q) |=> !irq_q)
        else $error("power interrupt not cleared");
    AST_RESET_RETRIGGER: assert property (@(posedge MCLK) disable iff (!RESET_N)
        clear_wr && !cps_q |=> irq_q)
        else $error("power interrupt not re-set while low");
    AST_BUSY_INVALID: assert property (@(posedge MCLK) disable iff (!RESET_N)
        LINE_BUSY |=> b_line_q == '0)
        else $error("line state not invalid while busy");
    AST_LINE_PASS: assert property (@(posedge MCLK) disable iff (!RESET_N)
        !LINE_BUSY |=> b_line_q == $past(CABLE_PAIR_B))
        else $error("line state not reported");
    AST_DISCONNECT_NOW: assert property (@(posedge MCLK) disable iff (!RESET_N)
        stable_q[0] && stable[0] && !CABLE_PRESENT[0] |=> ##1 BUS_RESET_REQ)
        else $error("disconnect did not reset bus");
    AST_DRIVE_OFF_INIT: assert property (@(posedge MCLK) disable iff (!RESET_N)
        init_q |=> !CABLE_DRIVE_EN)
        else $error("cable driven during start-up");
    AST_MGR_MIRROR: assert property (@(posedge MCLK) disable iff (!RESET_N)
        $past(RESET_N, 2) |-> SELF_ID_MGR == $past(MGR_CAPABLE_PIN, 2))
        else $error("manager flag not mirrored");
    AST_CON_UPDATE: assert property (@(posedge MCLK) disable iff (!RESET_N)
        BUS_RESET_REQ |=> con_q == $past(stable))
        else $error("connected flags not refreshed");
    AST_ROOT_AFTER_INIT: assert property (@(posedge MCLK) disable iff (!RESET_N)
        init_q && SELF_ID_DONE |=> IS_ROOT && PHY_ADDR == PHY_ADDR_ROOT)
        else $error("not root after start-up self-id");
    AST_CHILD_INIT: assert property (@(posedge MCLK) disable iff (!RESET_N)
        init_q |=> &child_q)
        else $error("ports not children during start-up");
    AST_CPS_FOLLOW: assert property (@(posedge MCLK) disable iff (!RESET_N)
        $past(RESET_N) |-> cps_q == $past(CABLE_POWER_SENSE))
        else $error("cable power status not following sense");
endmodule // pps_status_regs

// *** tb/phy_port_status_power_flags_tb_top.sv ***
`timescale 1ns/1ps
module phy_port_status_power_flags_tb_top import pps_pkg::*;;
    localparam int DBC = 8;
    logic MCLK = 0, RESET_N = 0, REG_WR, LINE_BUSY = 0, TREE_DONE = 0, SELF_ID_DONE = 0;
    logic MGR_CAPABLE_PIN = 0, CABLE_POWER_SENSE = 1;
    logic [ADDR_W-1:0] REG_ADDR;
    logic [DATA_W-1:0] REG_WDATA, REG_RDATA, r;
    logic [5:0] CABLE_PAIR_B = 6'h00;
    logic [2:0] CABLE_PRESENT = 3'h0, TREE_CHILD = 3'h0;
    logic BUS_RESET_REQ, CABLE_DRIVE_EN, SELF_ID_MGR, IS_ROOT;
    logic [7:0] PHY_ADDR;
    int fail_count = 0, samples_checked = 0, seed = 10, n;
    pps_status_regs #(.DEBOUNCE(DBC)) i_dut (
        .MCLK(MCLK),
        .RESET_N(RESET_N),
        .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR),
        .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA),
        .CABLE_PAIR_B(CABLE_PAIR_B),
        .CABLE_PRESENT(CABLE_PRESENT),
        .LINE_BUSY(LINE_BUSY),
        .TREE_CHILD(TREE_CHILD),
        .TREE_DONE(TREE_DONE),
        .SELF_ID_DONE(SELF_ID_DONE),
        .MGR_CAPABLE_PIN(MGR_CAPABLE_PIN),
        .CABLE_POWER_SENSE(CABLE_POWER_SENSE),
        .BUS_RESET_REQ(BUS_RESET_REQ),
        .CABLE_DRIVE_EN(CABLE_DRIVE_EN),
        .SELF_ID_MGR(SELF_ID_MGR),
        .IS_ROOT(IS_ROOT),
        .PHY_ADDR(PHY_ADDR)
    );
    pps_link_model i_link (.clk(MCLK), .addr(REG_ADDR), .wr(REG_WR), .wdata(REG_WDATA),
        .rdata(REG_RDATA));
    initial begin
        forever #5 MCLK = ~MCLK;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // expected port register: b-line code, child, con
    function automatic logic [7:0] port_exp(logic [1:0] b, logic ch, logic con);
        return {2'b00, b, ch, con, 2'b00};
    endfunction
    task automatic port_rd(input int p, input logic [7:0] m, input logic [7:0] e);
        i_link.rd_reg(REG_PORT1 + 4'(p), r);
        chk(r & m, e);
    endtask
    task automatic wait_req();
        n = 0;
        while (BUS_RESET_REQ !== 1'b1 && n < 100) begin
            @(posedge MCLK);
            #1 n++;
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge MCLK);
        #1 RESET_N = 1;
        port_rd(0, 8'h3c, port_exp(LINE_INVALID, 1, 0));
        for (int i = 0; i < 6; i++) begin
            CABLE_PAIR_B = 6'($random(seed));
            if (i == 0) CABLE_PAIR_B = {LINE_HIZ, LINE_ZERO, LINE_ONE};
            for (int p = 0; p < 3; p++) port_rd(p, 8'h30, port_exp(CABLE_PAIR_B[2*p+:2], 0, 0));
        end
        LINE_BUSY = 1;
        port_rd(1, 8'h30, 8'h00);
        LINE_BUSY = 0;
        for (int i = 0; i < 2; i++) begin
            MGR_CAPABLE_PIN = 1'($random(seed));
            i_link.rd_reg(REG_IRQ_CPS, r);
            chk(r & 8'h61, {7'h10, MGR_CAPABLE_PIN});
            i_link.rd_reg(REG_ID_CPS, r);
            chk(r & 8'h01, 8'h01);
        end
        CABLE_POWER_SENSE = 0;
        repeat (3) @(posedge MCLK);
        i_link.rd_reg(REG_IRQ_CPS, r);
        chk(r & 8'h60, 8'h40);
        i_link.wr_reg(REG_IRQ_CPS, 8'h00);
        i_link.rd_reg(REG_IRQ_CPS, r);
        chk(r & 8'h40, 8'h40);
        CABLE_POWER_SENSE = 1;
        repeat (3) @(posedge MCLK);
        i_link.wr_reg(REG_IRQ_CPS, 8'h00);
        i_link.rd_reg(REG_IRQ_CPS, r);
        chk(r & 8'h60, 8'h20);
        chk({7'h0, SELF_ID_MGR}, {7'h0, MGR_CAPABLE_PIN});
        i_link.rd_reg(4'h7, r);
        chk(r, 8'h00);
        @(posedge MCLK);
        #1 CABLE_PRESENT = 3'h1;
        wait_req();
        chk(8'(n >= DBC && n <= DBC + 4), 8'h01);
        repeat (3) @(posedge MCLK);
        #1 chk({7'h0, CABLE_DRIVE_EN}, 8'h01);
        port_rd(0, 8'h04, port_exp(0, 0, 1));
        @(posedge MCLK);
        #1 CABLE_PRESENT = 3'h0;
        wait_req();
        chk(8'(n <= 3), 8'h01);
        @(posedge MCLK);
        #1 TREE_CHILD = 3'h2;
        TREE_DONE = 1;
        @(posedge MCLK);
        #1 TREE_DONE = 0;
        port_rd(0, 8'h08, 8'h00);
        port_rd(1, 8'h08, 8'h08);
        SELF_ID_DONE = 1;
        @(posedge MCLK);
        #1 SELF_ID_DONE = 0;
        repeat (2) @(posedge MCLK);
        // root is only claimed in the start-up self-id, not after a bus reset
        #1 chk({IS_ROOT, PHY_ADDR[6:0]}, {1'b0, PHY_ADDR_ROOT[6:0]});
        CABLE_POWER_SENSE = 0;
        repeat (3) @(posedge MCLK);
        #1 RESET_N = 0;
        CABLE_POWER_SENSE = 1;
        repeat (3) @(posedge MCLK);
        #1 RESET_N = 1;
        chk({7'h0, CABLE_DRIVE_EN}, 8'h00);
        SELF_ID_DONE = 1;
        @(posedge MCLK);
        #1 SELF_ID_DONE = 0;
        @(posedge MCLK);
        #1 chk({IS_ROOT, PHY_ADDR[6:0]}, {1'b1, PHY_ADDR_ROOT[6:0]});
        i_link.rd_reg(REG_IRQ_CPS, r);
        chk(r & 8'h60, 8'h20);
        port_rd(0, 8'h0c, 8'h08);
        tally_and_finish();
    end
endmodule // phy_port_status_power_flags_tb_top

// *** tb/pps_link_model.sv ***
`timescale 1ns/1ps
// link-layer controller side of the register port
module pps_link_model import pps_pkg::*; (
    // clock
    input wire logic clk,
    // register port
    output logic [ADDR_W-1:0] addr,
    output logic wr,
    output logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata
);
    initial begin
        addr = 4'h0;
        wr = 1'b0;
        wdata = 8'h00;
    end
    // one-cycle write strobe, data inverted after release so nothing stale stays
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 addr = a;
        wr = 1'b1;
        wdata = d;
        @(posedge clk);
        #1 wr = 1'b0;
        wdata = ~d;
    endtask
    // address held; registered data taken a full cycle after it was sampled
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 addr = a;
        @(posedge clk);
        @(posedge clk);
        #1 d = rdata;
    endtask
endmodule // pps_link_model
